// File: hw/bdm_core.sv
// address generation, bank pointer, status flags and access of data memory
// assumes the core decoder holds a request until ready_o was high at the edge
module bdm_core
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic req_valid_i,
	input wire bdm_pkg::bdm_op_e req_op_i,
	input wire logic access_sel_i,
	input wire logic [bdm_pkg::OFFSET_W-1:0] offset_i,
	input wire logic [bdm_pkg::DATA_W-1:0] literal_i,
	input wire logic [bdm_pkg::DATA_W-1:0] wr_data_i,
	input wire logic [bdm_pkg::ADDR_W-1:0] src_addr_i,
	input wire logic [bdm_pkg::ADDR_W-1:0] dst_addr_i,
	input wire logic [bdm_pkg::FLAG_W-1:0] flags_i,
	input wire logic [bdm_pkg::FLAG_W-1:0] flags_we_i,
	input wire logic subtract_i,
	output logic ready_o,
	output logic [bdm_pkg::DATA_W-1:0] rd_data_o,
	output logic rd_valid_o,
	output logic done_o,
	output logic [bdm_pkg::BANK_W-1:0] bank_o,
	output logic [bdm_pkg::DATA_W-1:0] status_o,
	output logic [bdm_pkg::ADDR_W-1:0] addr_o
);
	import bdm_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_READ,
		ST_MOVE
	} bdm_state_e;

	localparam int PAD_BANK = DATA_W - BANK_W;
	localparam int PAD_FLAG = DATA_W - FLAG_W;

	bdm_state_e state_q, state_d;
	logic ready_q, ready_d;
	logic [BANK_W-1:0] bank_q, bank_d;
	logic [DATA_W-1:0] status_q, status_d;
	logic [DATA_W-1:0] rd_data_q, rd_data_d;
	logic rd_valid_q, rd_valid_d;
	logic done_q, done_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic src_ram_q;
	logic [DATA_W-1:0] src_sfr_q;
	logic [ADDR_W-1:0] dst_q;

	// ****************************************
	// request decode
	// ****************************************
	wire accept = req_valid_i & ready_q;
	wire is_read = accept & (req_op_i == OP_READ);
	wire is_write = accept & (req_op_i == OP_WRITE);
	wire is_flags = accept & (req_op_i == OP_FLAGS);
	wire is_load = accept & (req_op_i == OP_LOAD_BANK);
	wire is_move = accept & (req_op_i == OP_MOVE_FULL);
	wire in_move = (state_q == ST_MOVE);

	// ****************************************
	// address generation
	// ****************************************
	// access bank needs no pointer, so it resolves in the same cycle
	wire offset_low = (offset_i < ACCESS_SPLIT);
	wire [BANK_W-1:0] access_bank = offset_low ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK;
	wire [BANK_W-1:0] eff_bank = access_sel_i ? bank_q : access_bank;
	wire [ADDR_W-1:0] eff_addr = {eff_bank, offset_i};
	// the full move bypasses the pointer altogether
	wire [ADDR_W-1:0] rd_addr = (req_op_i == OP_MOVE_FULL) ? src_addr_i : eff_addr;

	// ****************************************
	// map decode
	// ****************************************
	// RAM grows from zero; the top bank holds only special registers
	wire [BANK_W-1:0] rd_bank = rd_addr[ADDR_W-1:ADDR_W-BANK_W];
	wire rd_ram_hit = IMPL_BANKS[rd_bank] & (rd_bank != SFR_BANK);
	wire [DATA_W-1:0] bank_word = {{PAD_BANK{1'b0}}, bank_q};
	wire rd_is_status = (rd_addr == STATUS_ADDR);
	wire rd_is_bank = (rd_addr == BANK_PTR_ADDR);
	// unused special locations and unbuilt banks answer zero
	wire [DATA_W-1:0] rd_sfr_val = rd_is_status ? status_q : (rd_is_bank ? bank_word : 8'h00);

	// ****************************************
	// write path
	// ****************************************
	wire [DATA_W-1:0] ram_rdata;
	wire [DATA_W-1:0] src_data = src_ram_q ? ram_rdata : src_sfr_q;
	wire wr_go = is_write | in_move;
	wire [ADDR_W-1:0] wr_addr = in_move ? dst_q : eff_addr;
	wire [DATA_W-1:0] wr_val = in_move ? src_data : wr_data_i;
	wire [BANK_W-1:0] wr_bank = wr_addr[ADDR_W-1:ADDR_W-BANK_W];
	wire wr_ram_hit = IMPL_BANKS[wr_bank] & (wr_bank != SFR_BANK);
	wire wr_is_status = (wr_addr == STATUS_ADDR);
	wire wr_is_bank = (wr_addr == BANK_PTR_ADDR);
	// writes into an unbuilt bank simply never reach the array
	wire mem_we = wr_go & wr_ram_hit;

	// ****************************************
	// status flags
	// ****************************************
	// the ALU reports true borrows; the register keeps them inverted
	wire [FLAG_W-1:0] flags_adj = flags_i ^ (subtract_i ? BORROW_FLAGS : 5'h00);
	wire alu_upd = (is_write | is_flags) & (|flags_we_i);
	wire [DATA_W-1:0] flag_mask = {{PAD_FLAG{1'b0}}, flags_we_i};
	wire [DATA_W-1:0] flag_val = {{PAD_FLAG{1'b0}}, flags_adj};
	wire [DATA_W-1:0] status_flagged = (status_q & ~flag_mask) | (flag_val & flag_mask);
	// flag update wins over a plain store, so a store of zero with Z set leaves the other status bits as they were
	// moves and plain stores carry no flags and land masked by STATUS_MASK
	assign status_d = alu_upd ? status_flagged :
		((wr_go & wr_is_status) ? (wr_val & STATUS_MASK) : status_q);

	// ****************************************
	// bank pointer
	// ****************************************
	assign bank_d = is_load ? literal_i[BANK_W-1:0] :
		((wr_go & wr_is_bank) ? wr_val[BANK_W-1:0] : bank_q);

	// ****************************************
	// sequencing
	// ****************************************
	always_comb
	begin
		state_d = ST_IDLE;
		case (state_q)
			ST_IDLE:
			begin
				if (is_read)
					state_d = ST_READ;
				else if (is_move)
					state_d = ST_MOVE;
			end
			ST_READ:
				state_d = ST_IDLE;
			ST_MOVE:
				state_d = ST_IDLE;
			default:
				state_d = ST_IDLE;
		endcase
	end

	assign ready_d = (state_d == ST_IDLE);
	assign rd_valid_d = (state_q == ST_READ);
	assign rd_data_d = (state_q == ST_READ) ? src_data : rd_data_q;
	assign done_d = is_write | is_flags | is_load | in_move;
	assign addr_d = in_move ? dst_q : ((is_read | is_move) ? rd_addr : (is_write ? eff_addr : addr_q));

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			state_q <= ST_IDLE;
			ready_q <= 1'b0;
			bank_q <= BANK_RESET;
			status_q <= STATUS_RESET;
			rd_data_q <= 8'h00;
			rd_valid_q <= 1'b0;
			done_q <= 1'b0;
			addr_q <= 12'h000;
		end
		else if (ce_i)
		begin
			state_q <= state_d;
			ready_q <= ready_d;
			bank_q <= bank_d;
			status_q <= status_d;
			rd_data_q <= rd_data_d;
			rd_valid_q <= rd_valid_d;
			done_q <= done_d;
			addr_q <= addr_d;
		end
	end

	// source snapshot taken at the request; no reset needed, read only after a load
	always_ff @(posedge clk_i)
	begin
		if (ce_i & (is_read | is_move))
		begin
			src_ram_q <= rd_ram_hit;
			src_sfr_q <= rd_sfr_val;
			dst_q <= dst_addr_i;
		end
	end

	// ****************************************
	// storage
	// ****************************************
	bdm_ram u_ram
	(
		.clk_i(clk_i),
		.ce_i(ce_i),
		.we_i(mem_we),
		.waddr_i(wr_addr),
		.wdata_i(wr_val),
		.re_i(is_read | is_move),
		.raddr_i(rd_addr),
		.rdata_o(ram_rdata)
	);

	assign ready_o = ready_q;
	assign rd_data_o = rd_data_q;
	assign rd_valid_o = rd_valid_q;
	assign done_o = done_q;
	assign bank_o = bank_q;
	assign status_o = status_q;
	assign addr_o = addr_q;
endmodule

// File: include/bdm_pkg.sv
// constants, opcodes and map of the banked data memory block
// assumes one core clock and a core that issues one request at a time
package bdm_pkg;

	// ****************************************
	// widths and sizes
	// ****************************************
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int BANK_W = 4;
	localparam int OFFSET_W = 8;
	localparam int FLAG_W = 5;
	localparam int MEM_DEPTH = 4096;
	localparam int BANK_COUNT = 16;

	// ****************************************
	// memory map
	// ****************************************
	localparam logic [OFFSET_W-1:0] ACCESS_SPLIT = 8'h60;
	localparam logic [BANK_W-1:0] ACCESS_LOW_BANK = 4'h0;
	localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hf;
	localparam logic [BANK_W-1:0] SFR_BANK = 4'hf;
	// one bit per bank, set where the bank is built
	localparam logic [BANK_COUNT-1:0] IMPL_BANKS = 16'h800f;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'hfff;
	localparam logic [ADDR_W-1:0] BANK_PTR_ADDR = 12'hffe;

	// ****************************************
	// register fields and reset values
	// ****************************************
	localparam logic [DATA_W-1:0] STATUS_MASK = 8'h1f;
	localparam logic [BANK_W-1:0] BANK_RESET = 4'h0;
	localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
	localparam int C_BIT = 0;
	localparam int DC_BIT = 1;
	localparam int Z_BIT = 2;
	localparam int OV_BIT = 3;
	localparam int N_BIT = 4;
	localparam logic [FLAG_W-1:0] BORROW_FLAGS = 5'h03;

	// ****************************************
	// requests from the core
	// ****************************************
	typedef enum logic [2:0] {
		OP_NONE,
		OP_READ,
		OP_WRITE,
		OP_FLAGS,
		OP_LOAD_BANK,
		OP_MOVE_FULL
	} bdm_op_e;

endpackage

// File: hw/bdm_ram.sv
// byte-wide data storage with one write port and one registered read port
// assumes the owner gates writes to built banks; contents have no reset
module bdm_ram
(
	input wire logic clk_i,
	input wire logic ce_i,
	input wire logic we_i,
	input wire logic [bdm_pkg::ADDR_W-1:0] waddr_i,
	input wire logic [bdm_pkg::DATA_W-1:0] wdata_i,
	input wire logic re_i,
	input wire logic [bdm_pkg::ADDR_W-1:0] raddr_i,
	output logic [bdm_pkg::DATA_W-1:0] rdata_o
);
	import bdm_pkg::*;

	logic [DATA_W-1:0] mem [0:MEM_DEPTH-1];
	logic [DATA_W-1:0] rdata_q;

	// ****************************************
	// storage
	// ****************************************
	// no reset here on purpose: data must survive every reset
	always_ff @(posedge clk_i)
	begin
		if (ce_i)
		begin
			if (we_i)
				mem[waddr_i] <= wdata_i;
			if (re_i)
				rdata_q <= mem[raddr_i];
		end
	end

	assign rdata_o = rdata_q;
endmodule

// File: test/bdm_chk_checker.sv
// assertions on the request port of bdm_core
// assumes it is bound to bdm_core and that ce_i only drops with no request in flight
module bdm_chk
	import bdm_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic req_valid_i,
	input wire bdm_pkg::bdm_op_e req_op_i,
	input wire logic access_sel_i,
	input wire logic [7:0] offset_i,
	input wire logic [7:0] literal_i,
	input wire logic [11:0] src_addr_i,
	input wire logic [11:0] dst_addr_i,
	input wire logic [4:0] flags_i,
	input wire logic [4:0] flags_we_i,
	input wire logic subtract_i,
	input wire logic ready_o,
	input wire logic [7:0] rd_data_o,
	input wire logic rd_valid_o,
	input wire logic done_o,
	input wire logic [3:0] bank_o,
	input wire logic [7:0] status_o,
	input wire logic [11:0] addr_o
);
	// ****
	// helpers
	// ****
	logic t;
	logic [4:0] fx;
	logic [4:0] fn;
	logic [7:0] lit_q;
	assign t = req_valid_i & ready_o & ce_i;
	assign fx = flags_i ^ (subtract_i ? BORROW_FLAGS : 5'h00);
	assign fn = (status_o[4:0] & ~flags_we_i) | (fx & flags_we_i);
	always_ff @(posedge clk_i)
		lit_q <= literal_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	a_load_bank: assert property (t && req_op_i == OP_LOAD_BANK |=> done_o && bank_o == lit_q[3:0])
		else $error("bank pointer not loaded");
	a_banked_addr: assert property (t && req_op_i == OP_WRITE && access_sel_i
		|=> addr_o == {$past(bank_o), $past(offset_i)})
		else $error("banked address wrong");
	a_access_map: assert property (t && req_op_i == OP_READ && !access_sel_i
		|=> !ready_o && addr_o == {($past(offset_i) < 8'h60) ? 4'h0 : 4'hf, $past(offset_i)} ##1 rd_valid_o)
		else $error("access bank read wrong");
	a_ptr_read: assert property (t && req_op_i == OP_READ && !access_sel_i && offset_i == 8'hfe
		|=> ##1 rd_data_o == {4'h0, $past(bank_o, 2)})
		else $error("bank pointer read wrong");
	a_unbuilt_zero: assert property (t && req_op_i == OP_READ && access_sel_i && !IMPL_BANKS[bank_o]
		|=> ##1 rd_data_o == 8'h00)
		else $error("unbuilt bank read not zero");
	a_move_full: assert property (t && req_op_i == OP_MOVE_FULL |=> addr_o == $past(src_addr_i)
		##1 done_o && addr_o == $past(dst_addr_i, 2))
		else $error("full move addresses wrong");
	a_flag_update: assert property (t && req_op_i inside {OP_WRITE, OP_FLAGS}
		&& flags_we_i != 5'h00 |=> status_o == {3'h0, $past(fn)})
		else $error("status flags wrong");
	a_status_top: assert property (status_o[7:5] == 3'h0)
		else $error("status top bits set");
endmodule
bind bdm_core bdm_chk u_chk (.clk_i, .reset_i, .ce_i, .req_valid_i, .req_op_i, .access_sel_i, .offset_i, .literal_i,
	.src_addr_i, .dst_addr_i, .flags_i, .flags_we_i, .subtract_i, .ready_o, .rd_data_o, .rd_valid_o, .done_o,
	.bank_o, .status_o, .addr_o);

// File: test/bdm_req_model.sv
// core decoder side: issues one request at a time and waits for its answer
// assumes clk_i is the core clock; a hang is reported to the bench top
module bdm_req_model
	import bdm_pkg::*;
(
	input wire logic clk_i,
	input wire logic ready_i,
	input wire logic ack_i,
	output logic valid_o,
	output bdm_op_e op_o,
	output logic sel_o,
	output logic [7:0] off_o,
	output logic [7:0] dat_o,
	output logic [11:0] src_o,
	output logic [11:0] dst_o,
	output logic [4:0] fl_o,
	output logic [4:0] fwe_o,
	output logic sub_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
		valid_o = 1'b0;
	task automatic go(input bdm_op_e p, input logic s, input logic [7:0] o, d, input logic [11:0] a, b,
		input logic [4:0] f, w, input logic u);
		int n;
		@(negedge clk_i);
		valid_o = 1'b1;
		op_o = p;
		sel_o = s;
		off_o = o;
		dat_o = d;
		src_o = a;
		dst_o = b;
		fl_o = f;
		fwe_o = w;
		sub_o = u;
		// held until ready is seen high ahead of the taking edge
		for (n = 0; n < 20 && ready_i !== 1'b1; n++)
			@(negedge clk_i);
		if (ready_i !== 1'b1)
			banked_data_memory_addressing_tb.hang();
		@(negedge clk_i);
		valid_o = 1'b0;
		// released offset and data lines flip so a stale value is never mistaken for a held one
		off_o = ~off_o;
		dat_o = ~dat_o;
		for (n = 0; n < 4 && ack_i !== 1'b1; n++)
			@(negedge clk_i);
		if (ack_i !== 1'b1)
			banked_data_memory_addressing_tb.hang();
	endtask
endmodule

// File: test/banked_data_memory_addressing_tb.sv
// self-checking bench for bdm_core driven through the request model
// assumes ce_i drops only between requests; inputs change on the falling edge
module banked_data_memory_addressing_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import bdm_pkg::*;
	logic clk = 0;
	logic rst = 1;
	logic ce = 1;
	logic valid, sel, sub, ready, rdv, done;
	bdm_op_e op;
	logic [7:0] off, dat, rdd, st;
	logic [11:0] src, dst, addr;
	logic [4:0] fl, fwe;
	logic [3:0] bank;
	int err_total = 0;
	int samples_checked = 0;
	always #12.5 clk = ~clk;
	bdm_core uut (.clk_i(clk), .reset_i(rst), .ce_i(ce), .req_valid_i(valid), .req_op_i(op), .access_sel_i(sel),
		.offset_i(off), .literal_i(dat), .wr_data_i(dat), .src_addr_i(src), .dst_addr_i(dst), .flags_i(fl),
		.flags_we_i(fwe), .subtract_i(sub), .ready_o(ready), .rd_data_o(rdd), .rd_valid_o(rdv), .done_o(done),
		.bank_o(bank), .status_o(st), .addr_o(addr));
	bdm_req_model pm (.clk_i(clk), .ready_i(ready), .ack_i(rdv | done), .valid_o(valid), .op_o(op), .sel_o(sel),
		.off_o(off), .dat_o(dat), .src_o(src), .dst_o(dst), .fl_o(fl), .fwe_o(fwe), .sub_o(sub));
	// ****
	// tasks
	// ****
	task tally_and_finish;
		$display("checks=%0d errors=%0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task hang;
		err_total++;
		tally_and_finish();
	endtask
	task chk(input logic [11:0] g, e);
		samples_checked++;
		if (g !== e)
		begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task wr(input logic s, input logic [7:0] o, d, input logic [4:0] f = 5'h00, w = 5'h00);
		pm.go(OP_WRITE, s, o, d, 12'h000, 12'h000, f, w, 1'b0);
	endtask
	task rd(input logic s, input logic [7:0] o, e);
		pm.go(OP_READ, s, o, 8'h00, 12'h000, 12'h000, 5'h00, 5'h00, 1'b0);
		chk(12'(rdd), 12'(e));
	endtask
	task ld(input logic [7:0] l);
		pm.go(OP_LOAD_BANK, 1'b0, 8'h00, l, 12'h000, 12'h000, 5'h00, 5'h00, 1'b0);
	endtask
	initial
	begin
		repeat (3) @(negedge clk);
		rst = 0;
		@(negedge clk);
		chk(12'(st), 12'h000);
		ld(8'hf1);
		chk(12'(bank), 12'h001);
		wr(1'b1, 8'h23, 8'ha5);
		chk(addr, 12'h123);
		wr(1'b0, 8'h23, 8'h5a);
		chk(addr, 12'h023);
		rd(1'b1, 8'h23, 8'ha5);
		rd(1'b0, 8'h23, 8'h5a);
		rd(1'b0, 8'h80, 8'h00);
		chk(addr, 12'hf80);
		pm.go(OP_MOVE_FULL, 1'b0, 8'h00, 8'h00, 12'h123, 12'h3ff, 5'h00, 5'h00, 1'b0);
		chk(addr, 12'h3ff);
		ld(8'h03);
		rd(1'b1, 8'hff, 8'ha5);
		ld(8'h05);
		wr(1'b1, 8'h10, 8'h77, 5'h04, 5'h1f);
		chk(12'(st), 12'h004);
		rd(1'b1, 8'h10, 8'h00);
		wr(1'b0, 8'hff, 8'h1b);
		wr(1'b0, 8'hff, 8'h00, 5'h04, 5'h04);
		chk(12'(st), 12'h01f);
		pm.go(OP_FLAGS, 1'b0, 8'h00, 8'h00, 12'h000, 12'h000, 5'h01, 5'h03, 1'b1);
		chk(12'(st), 12'h01e);
		wr(1'b0, 8'hfe, 8'hf7);
		chk(12'(bank), 12'h007);
		// enable low: the done pulse and the pointer must both freeze
		ce = 0;
		repeat (2) @(negedge clk);
		chk(12'(done), 12'h001);
		chk(12'(bank), 12'h007);
		ce = 1;
		rd(1'b0, 8'hfe, 8'h07);
		// second reset: the ram has to come through untouched
		rst = 1;
		repeat (3) @(negedge clk);
		rst = 0;
		@(negedge clk);
		chk(12'(bank), 12'h000);
		rd(1'b0, 8'h23, 8'h5a);
		tally_and_finish();
	end
endmodule
